// ===== verification/testbench.sv
`timescale 1ns/1ps
// ==========================================
// Testbench top
module testbench
    import tspi_pkg::*;
;
    logic clock = 0;
    logic rst = 1;
    logic refDiffValid = 0;
    logic signed [DIFF_WIDTH-1:0] refDiff = '0;
    logic [3:0] operatingMode = 4'h0;
    logic [7:0] timeHoursBcd = 8'h03;
    tspi_bus_s bus;
    logic [7:0] hostRdata;
    tspi_setup_s setup;
    logic rtcLoad;
    logic [47:0] rtcBcd;
    logic [7:0] localHoursBcd;
    logic jamPulse;
    logic [7:0] d;
    logic clockEnable = 1;
    logic [15:0] dacValue = 16'hA1F9;
    int n_mismatch = 0;
    int checks_done = 0;

    always #2.5 clock = ~clock;

    tspi_host_model host_u (.clock(clock), .bus(bus), .hostRdata(hostRdata));

    tspi_interpreter dut_u (.clock(clock), .rst(rst),
        .clockEnable(clockEnable),
        .bus(bus), .hostRdata(hostRdata), .operatingMode(operatingMode),
        .calendarBcd(48'h2401_3123_5958), .dacValue(dacValue),
        .leapBcd(8'h37), .hbMode(8'h32), .hbCount1(16'h0063),
        .hbCount2(16'h0009), .timeHoursBcd(timeHoursBcd),
        .refDiffValid(refDiffValid), .refDiff(refDiff), .setup(setup),
        .rtcLoad(rtcLoad), .rtcBcd(rtcBcd), .localHoursBcd(localHoursBcd),
        .jamPulse(jamPulse));

    // ==========================================
    // Comparison and verdict
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // One request, its whole response, a read past the end, the clear.
    task automatic req_check(input logic [7:0] t, input logic [7:0] e[$]);
        host_u.send('{CMD_REQ, t});
        host_u.rd(REG_ACK, d);
        chk(d[ACK_READY_BIT], 1);
        foreach (e[i])
        begin
            host_u.rd(REG_RESP, d);
            chk(d, e[i]);
        end
        host_u.rd(REG_RESP, d);
        chk(d, 8'h00);
        host_u.ack_clear();
        host_u.rd(REG_ACK, d);
        chk(d[ACK_READY_BIT], 0);
    endtask : req_check

    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end

    // ==========================================
    // Scenarios
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 0;
        #1 chk(setup.extClock, 0);
        chk(setup.format, ASC_B);
        host_u.send('{CMD_CLK, ASC_E});
        #1 chk(setup.extClock, 1);
        @(posedge clock);
        rst <= 1;
        @(posedge clock);
        rst <= 0;
        #1 chk(setup.extClock, 0);
        host_u.send('{CMD_CLK, ASC_E});
        #1 chk(setup.extClock, 1);
        host_u.send('{CMD_CLK, ASC_T});
        #1 chk(setup.extClock, 0);
        @(posedge clock);
        clockEnable <= 0;
        host_u.send('{CMD_CLK, ASC_E});
        #1 chk(setup.extClock, 0);
        @(posedge clock);
        clockEnable <= 1;
        host_u.send('{CMD_FMT, ASC_X, ASC_D});
        #1 chk(setup.format, ASC_B);
        host_u.send('{CMD_FMT, ASC_C, ASC_M});
        #1 chk({setup.format, setup.modulation}, {ASC_C, ASC_M});
        host_u.send('{CMD_GEN, ASC_H});
        #1 chk(setup.genCode, ASC_H);
        host_u.send('{CMD_PATH, 8'h30, 8'h35});
        #1 chk({setup.pathA, setup.pathB}, 8'h05);
        host_u.send('{CMD_PROP, ASC_MINUS, 8'h31, 8'h32, 8'h33, 8'h34,
            8'h35, 8'h36, 8'h39});
        #1 chk({setup.propSign, setup.propDigits},
            {ASC_MINUS, 56'h3132_3334_3536_39});
        host_u.send('{CMD_RTC, 8'h32, 8'h34, 8'h30, 8'h31, 8'h33, 8'h31,
            8'h32, 8'h33, 8'h35, 8'h39, 8'h35, 8'h38});
        #1 chk({rtcLoad, rtcBcd}, {1'b1, 48'h2401_3123_5958});
        req_check(8'h32, '{SOH, RESP_LETTER, 8'h32, 8'h33, 8'h37,
            ETB});
        req_check(8'h31, '{SOH, RESP_LETTER, 8'h31, 8'h41, 8'h31, 8'h46,
            8'h39, ETB});
        @(posedge clock);
        operatingMode <= MODE_LOCAL;
        host_u.send('{CMD_LOCAL, ASC_MINUS, 8'h30, 8'h35});
        repeat (2) @(posedge clock);
        #1 chk(localHoursBcd, 8'h22);
        @(posedge clock);
        operatingMode <= 4'h0;
        repeat (2) @(posedge clock);
        #1 chk(localHoursBcd, 8'h03);
        @(posedge clock);
        refDiffValid <= 1;
        refDiff <= 32'sd10001;
        repeat (2) @(posedge clock);
        #1 chk(jamPulse, 0);
        host_u.send('{CMD_PATH, 8'h30, 8'h31});
        repeat (2) @(posedge clock);
        #1 chk(jamPulse, 1);
        @(posedge clock);
        refDiff <= -32'sd10000;
        repeat (2) @(posedge clock);
        #1 chk(jamPulse, 0);
        close_out();
    end
endmodule : testbench

// ===== verification/tspi_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host software model driving the register port
module tspi_host_model
    import tspi_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output tspi_bus_s bus,
    input wire logic [7:0] hostRdata
);
    initial bus = '0;

    // Idle lines show the inverse of the last value, never a stale copy.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '{~a, ~d, 1'b0, 1'b0};
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{a, ~bus.wdata, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '{~a, ~bus.wdata, 1'b0, 1'b0};
        // Read data stand only in the cycle after the strobe.
        #1 d = hostRdata;
    endtask : rd

    // Whole packets only, framed by start and end bytes.
    task automatic send(input logic [7:0] b[$]);
        wr(REG_FIFO, SOH);
        foreach (b[i]) wr(REG_FIFO, b[i]);
        wr(REG_FIFO, ETB);
    endtask : send

    // One request at a time, and the ready flag is cleared after use.
    task automatic ack_clear();
        wr(REG_ACK, 8'h04);
    endtask : ack_clear
endmodule : tspi_host_model

// ===== verilog/tspi_interpreter.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tspi_interpreter
    import tspi_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    // Register port
    input wire tspi_bus_s bus,
    output logic [7:0] hostRdata,
    // Firmware state
    input wire logic [3:0] operatingMode,
    input wire logic [47:0] calendarBcd,
    input wire logic [15:0] dacValue,
    input wire logic [7:0] leapBcd,
    input wire logic [7:0] hbMode,
    input wire logic [15:0] hbCount1,
    input wire logic [15:0] hbCount2,
    input wire logic [7:0] timeHoursBcd,
    input wire logic refDiffValid,
    input wire logic signed [DIFF_WIDTH-1:0] refDiff,
    // Settings and actions
    output tspi_setup_s setup,
    output logic rtcLoad,
    output logic [47:0] rtcBcd,
    output logic [7:0] localHoursBcd,
    output logic jamPulse
);

    tspi_state_e state;
    logic [3:0] pktLen;
    logic [7:0] pktBuf [PKT_MAX];
    logic [7:0] respBuf [RESP_MAX];
    logic [7:0] respNew [RESP_MAX];
    logic [4:0] respLen;
    logic [4:0] respNewLen;
    logic [4:0] respPtr;
    logic respReady;
    logic fifoWr;
    logic ackWr;
    logic respRd;
    logic execNow;
    logic [7:0] cmd;
    logic fmtOk;
    logic reqOk;
    logic execReq;

    function automatic logic [7:0] hexAsc(input logic [3:0] n);
        hexAsc = (n < HEX_TEN) ? ASC_ZERO + {4'h0, n}
            : ASC_A + {4'h0, n - HEX_TEN};
    endfunction : hexAsc

    function automatic logic [4:0] bcdVal(input logic [7:0] b);
        bcdVal = 5'(b[7:4] * 4'hA + b[3:0]);
    endfunction : bcdVal

    // ==================================================================
    // Decode of the register port
    assign fifoWr = clockEnable && bus.wr && bus.addr == REG_FIFO;
    assign ackWr = clockEnable && bus.wr && bus.addr == REG_ACK;
    assign respRd = clockEnable && bus.rd && bus.addr == REG_RESP;
    assign execNow = fifoWr && state == ST_BODY && bus.wdata == ETB;
    assign cmd = pktBuf[0];
    assign fmtOk = (pktBuf[1] == ASC_A || pktBuf[1] == ASC_B
        || pktBuf[1] == ASC_C || pktBuf[1] == ASC_N
        || pktBuf[1] == ASC_X)
        && (pktBuf[2] == ASC_M || pktBuf[2] == ASC_D)
        && !(pktBuf[2] == ASC_D
        && (pktBuf[1] == ASC_C || pktBuf[1] == ASC_X));
    assign reqOk = pktBuf[1] >= ASC_ZERO && pktBuf[1] <= ASC_THREE;
    assign execReq = execNow && cmd == CMD_REQ && pktLen == LEN_REQ
        && reqOk;

    // ==================================================================
    // Packet framing
    // A new SOH always restarts, so a torn packet cannot poison the next.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            pktLen <= '0;
        end
        else if (fifoWr)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (bus.wdata == SOH)
                    begin
                        state <= ST_BODY;
                        pktLen <= '0;
                    end
                end
                ST_BODY:
                begin
                    if (bus.wdata == SOH)
                        pktLen <= '0;
                    else if (bus.wdata == ETB || pktLen == PKT_MAX)
                        state <= ST_IDLE;
                    else
                        pktLen <= pktLen + 4'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (fifoWr && state == ST_BODY && bus.wdata != SOH
            && bus.wdata != ETB && pktLen != PKT_MAX)
            pktBuf[pktLen] <= bus.wdata;
    end

    // ==================================================================
    // Settings
    // The retained settings take their defaults on every reset.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            setup.propSign <= ASC_PLUS;
            setup.propDigits <= {PROP_DIGITS{ASC_ZERO}};
            setup.format <= ASC_B;
            setup.modulation <= ASC_M;
            setup.genCode <= ASC_B;
            setup.localSign <= ASC_PLUS;
            setup.localTens <= ASC_ZERO;
            setup.localUnits <= ASC_ZERO;
        end
        else if (execNow)
        begin
            if (cmd == CMD_PROP && pktLen == LEN_PROP
                && (pktBuf[1] == ASC_PLUS || pktBuf[1] == ASC_MINUS))
            begin
                setup.propSign <= pktBuf[1];
                for (int i = 0; i < PROP_DIGITS; i++)
                    setup.propDigits[8*(PROP_DIGITS-1-i) +: 8]
                        <= pktBuf[2+i];
            end
            if (cmd == CMD_FMT && pktLen == LEN_FMT && fmtOk)
            begin
                setup.format <= pktBuf[1];
                setup.modulation <= pktBuf[2];
            end
            if (cmd == CMD_GEN && pktLen == LEN_GEN
                && (pktBuf[1] == ASC_B || pktBuf[1] == ASC_H))
                setup.genCode <= pktBuf[1];
            if (cmd == CMD_LOCAL && pktLen == LEN_LOCAL
                && (pktBuf[1] == ASC_PLUS || pktBuf[1] == ASC_MINUS))
            begin
                setup.localSign <= pktBuf[1];
                setup.localTens <= pktBuf[2];
                setup.localUnits <= pktBuf[3];
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            setup.extClock <= 1'b0;
        else if (execNow && cmd == CMD_CLK && pktLen == LEN_CLK)
        begin
            if (pktBuf[1] == ASC_E)
                setup.extClock <= 1'b1;
            else if (pktBuf[1] == ASC_T)
                setup.extClock <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            setup.pathA <= DEF_PATH_A;
            setup.pathB <= DEF_PATH_B;
        end
        else if (execNow && cmd == CMD_PATH && pktLen == LEN_PATH)
        begin
            setup.pathA <= pktBuf[1][3:0];
            setup.pathB <= pktBuf[2][3:0];
        end
    end

    // ==================================================================
    // Calendar load
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rtcLoad <= 1'b0;
            rtcBcd <= '0;
        end
        else if (clockEnable)
        begin
            rtcLoad <= execNow && cmd == CMD_RTC && pktLen == LEN_RTC;
            if (execNow && cmd == CMD_RTC && pktLen == LEN_RTC)
                for (int i = 0; i < RTC_DIGITS; i++)
                    rtcBcd[4*(RTC_DIGITS-1-i) +: 4] <= pktBuf[1+i][3:0];
        end
    end

    // ==================================================================
    // Local hours
    logic [4:0] hourNow;
    logic [4:0] hourOff;
    logic [5:0] hourSum;
    logic [4:0] hourLocal;
    assign hourNow = bcdVal(timeHoursBcd);
    assign hourOff = bcdVal({setup.localTens[3:0], setup.localUnits[3:0]});
    assign hourSum = (setup.localSign == ASC_MINUS)
        ? 6'(hourNow) + 6'(HOURS_PER_DAY) - 6'(hourOff)
        : 6'(hourNow) + 6'(hourOff);
    assign hourLocal = 5'(hourSum % 6'(HOURS_PER_DAY));

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            localHoursBcd <= '0;
        else if (clockEnable)
        begin
            if (operatingMode == MODE_LOCAL)
                localHoursBcd <= {4'(hourLocal / 5'd10),
                    4'(hourLocal % 5'd10)};
            else
                localHoursBcd <= timeHoursBcd;
        end
    end

    // ==================================================================
    // Response assembly
    always_comb
    begin
        for (int i = 0; i < RESP_MAX; i++)
            respNew[i] = 8'h00;
        respNew[0] = SOH;
        respNew[1] = RESP_LETTER;
        respNew[2] = pktBuf[1];
        respNewLen = RESP_LEN_LEAP;
        case (pktBuf[1][1:0])
            2'h0:
            begin
                for (int i = 0; i < RTC_DIGITS; i++)
                    respNew[3+i] = ASC_ZERO
                        + {4'h0, calendarBcd[4*(RTC_DIGITS-1-i) +: 4]};
                respNewLen = RESP_LEN_RTC;
            end
            2'h1:
            begin
                for (int i = 0; i < 4; i++)
                    respNew[3+i] = hexAsc(dacValue[4*(3-i) +: 4]);
                respNewLen = RESP_LEN_DAC;
            end
            2'h2:
            begin
                respNew[3] = ASC_ZERO + {4'h0, leapBcd[7:4]};
                respNew[4] = ASC_ZERO + {4'h0, leapBcd[3:0]};
                respNewLen = RESP_LEN_LEAP;
            end
            default:
            begin
                respNew[3] = ASC_ZERO + {4'h0, operatingMode};
                respNew[4] = setup.format;
                respNew[5] = setup.modulation;
                respNew[6] = setup.genCode;
                respNew[7] = hexAsc(setup.pathA);
                respNew[8] = hexAsc(setup.pathB);
                respNew[9] = setup.localSign;
                respNew[10] = setup.localTens;
                respNew[11] = setup.localUnits;
                respNew[12] = setup.propSign;
                for (int i = 0; i < PROP_DIGITS; i++)
                    respNew[13+i] =
                        setup.propDigits[8*(PROP_DIGITS-1-i) +: 8];
                respNew[20] = hbMode;
                for (int i = 0; i < 4; i++)
                begin
                    respNew[21+i] = hexAsc(hbCount1[4*(3-i) +: 4]);
                    respNew[25+i] = hexAsc(hbCount2[4*(3-i) +: 4]);
                end
                respNewLen = RESP_LEN_SETUP;
            end
        endcase
        respNew[respNewLen-5'h1] = ETB;
    end

    always_ff @(posedge clock)
    begin
        if (execReq)
            for (int i = 0; i < RESP_MAX; i++)
                respBuf[i] <= respNew[i];
    end

    // ==================================================================
    // Ready flag, read pointer and read data
    // A request landing with the clear keeps the flag, so nothing is lost.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            respReady <= 1'b0;
        else if (execReq)
            respReady <= 1'b1;
        else if (ackWr && bus.wdata[ACK_READY_BIT])
            respReady <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            respLen <= '0;
            respPtr <= '0;
        end
        else if (execReq)
        begin
            respLen <= respNewLen;
            respPtr <= '0;
        end
        else if (respRd && respPtr < respLen)
            respPtr <= respPtr + 5'h1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            hostRdata <= '0;
        else if (clockEnable)
        begin
            hostRdata <= '0;
            if (bus.rd && bus.addr == REG_ACK)
                hostRdata[ACK_READY_BIT] <= respReady;
            else if (respRd && respPtr < respLen)
                hostRdata <= respBuf[respPtr];
        end
    end

    // ==================================================================
    // Jam control
    tspi_jam_detector u_jam (
        .clock(clock),
        .rst(rst),
        .clockEnable(clockEnable),
        .jamEnable(!setup.pathB[PATH_JAM_OFF_BIT]),
        .refDiffValid(refDiffValid),
        .refDiff(refDiff),
        .jamPulse(jamPulse)
    );

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_READY_ON_REQUEST: assert property (execReq |=> respReady)
        else $error("Request did not raise the ready flag.");

    AST_READY_CLEAR: assert property (
        ackWr && bus.wdata[ACK_READY_BIT] && !execReq |=> !respReady)
        else $error("Ready flag survived its clear.");

    AST_INTERNAL_AT_POWER: assert property (
        $past(rst) |-> !setup.extClock)
        else $error("External clock selected after reset.");

    AST_NO_DC_SLOW_CODES: assert property (
        setup.modulation == ASC_D |->
        setup.format != ASC_C && setup.format != ASC_X)
        else $error("Level shift stored with an unsupported code.");

    AST_RESPONSE_FRAME: assert property (
        execReq |=> respBuf[0] == SOH && respBuf[1] == RESP_LETTER
        && respBuf[respLen-5'h1] == ETB && respPtr == 5'h0)
        else $error("Response frame malformed.");

    AST_SETUP_LENGTH: assert property (
        execReq && pktBuf[1] == ASC_THREE |=> respLen == RESP_LEN_SETUP)
        else $error("Setup response has the wrong length.");

    AST_HOURS_PASS: assert property (
        clockEnable && operatingMode != MODE_LOCAL
        |=> localHoursBcd == $past(timeHoursBcd))
        else $error("Hour offset applied outside mode 4.");

    AST_ACT_AT_END: assert property (
        fifoWr && bus.wdata != ETB |=> $stable(setup.extClock))
        else $error("Setting changed before the end byte.");

    COV_SETUP_REQUEST: cover property (execReq && pktBuf[1] == ASC_THREE);
    COV_FORMAT_LOAD: cover property (execNow && cmd == CMD_FMT && fmtOk);
    COV_READY_CLEARED: cover property (respReady ##1 !respReady);

endmodule : tspi_interpreter

// ===== verilog/tspi_jam_detector.sv
`timescale 1ns/1ps
module tspi_jam_detector
    import tspi_pkg::*;
#(
    parameter int LIMIT_TICKS = JAM_LIMIT_TICKS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    // Jam enable and measured difference, in offset units
    input wire logic jamEnable,
    input wire logic refDiffValid,
    input wire logic signed [DIFF_WIDTH-1:0] refDiff,
    // Jam request
    output logic jamPulse
);

    logic [DIFF_WIDTH-1:0] magnitude;
    logic overLimit;

    assign magnitude = refDiff[DIFF_WIDTH-1] ? DIFF_WIDTH'(-refDiff)
        : DIFF_WIDTH'(refDiff);
    assign overLimit = magnitude > DIFF_WIDTH'(LIMIT_TICKS);

    // ==================================================================
    // Jam decision
    // A jam replaces a long steering run when the error is gross.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            jamPulse <= 1'b0;
        else if (clockEnable)
            jamPulse <= jamEnable && refDiffValid && overLimit;
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_JAM_ON_GROSS_ERROR: assert property (
        clockEnable && jamEnable && refDiffValid && overLimit |=> jamPulse)
        else $error("Gross error did not jam the time base.");

    AST_NO_JAM_SMALL: assert property (
        clockEnable && !(jamEnable && overLimit) |=> !jamPulse)
        else $error("Jam raised without cause.");

    COV_JAM: cover property (jamPulse);

endmodule : tspi_jam_detector

// ===== verilog/tspi_pkg.sv
package tspi_pkg;

    // ==================================================================
    // Packet framing and command letters
    localparam logic [7:0] SOH = 8'h01;
    localparam logic [7:0] ETB = 8'h17;
    localparam logic [7:0] CMD_PROP = 8'h47;
    localparam logic [7:0] CMD_FMT = 8'h48;
    localparam logic [7:0] CMD_CLK = 8'h49;
    localparam logic [7:0] CMD_GEN = 8'h4B;
    localparam logic [7:0] CMD_RTC = 8'h4C;
    localparam logic [7:0] CMD_LOCAL = 8'h4D;
    localparam logic [7:0] CMD_REQ = 8'h4F;
    localparam logic [7:0] CMD_PATH = 8'h50;
    localparam logic [7:0] RESP_LETTER = 8'h6F;

    // ==================================================================
    // Body lengths, command letter included, framing bytes excluded
    localparam int PKT_WIDTH = 4;
    localparam logic [3:0] PKT_MAX = 4'hE;
    localparam logic [3:0] LEN_PROP = 4'h9;
    localparam logic [3:0] LEN_FMT = 4'h3;
    localparam logic [3:0] LEN_CLK = 4'h2;
    localparam logic [3:0] LEN_GEN = 4'h2;
    localparam logic [3:0] LEN_RTC = 4'hD;
    localparam logic [3:0] LEN_LOCAL = 4'h4;
    localparam logic [3:0] LEN_REQ = 4'h2;
    localparam logic [3:0] LEN_PATH = 4'h3;
    localparam int PROP_DIGITS = 7;
    localparam int RTC_DIGITS = 12;

    // ==================================================================
    // ASCII values used as selectors
    localparam logic [7:0] ASC_ZERO = 8'h30;
    localparam logic [7:0] ASC_THREE = 8'h33;
    localparam logic [7:0] ASC_A = 8'h41;
    localparam logic [7:0] ASC_B = 8'h42;
    localparam logic [7:0] ASC_C = 8'h43;
    localparam logic [7:0] ASC_D = 8'h44;
    localparam logic [7:0] ASC_E = 8'h45;
    localparam logic [7:0] ASC_H = 8'h48;
    localparam logic [7:0] ASC_M = 8'h4D;
    localparam logic [7:0] ASC_N = 8'h4E;
    localparam logic [7:0] ASC_T = 8'h54;
    localparam logic [7:0] ASC_X = 8'h58;
    localparam logic [7:0] ASC_PLUS = 8'h2B;
    localparam logic [7:0] ASC_MINUS = 8'h2D;
    localparam logic [3:0] HEX_TEN = 4'hA;

    // ==================================================================
    // Responses
    localparam int RESP_MAX = 30;
    localparam logic [4:0] RESP_LEN_RTC = 5'h10;
    localparam logic [4:0] RESP_LEN_DAC = 5'h08;
    localparam logic [4:0] RESP_LEN_LEAP = 5'h06;
    localparam logic [4:0] RESP_LEN_SETUP = 5'h1E;

    // ==================================================================
    // Register port
    localparam logic [3:0] REG_ACK = 4'hB;
    localparam logic [3:0] REG_RESP = 4'hC;
    localparam logic [3:0] REG_FIFO = 4'hE;
    localparam int ACK_READY_BIT = 2;

    // ==================================================================
    // Defaults and fields
    localparam logic [3:0] DEF_PATH_A = 4'h0;
    localparam logic [3:0] DEF_PATH_B = 4'h1;
    localparam int PATH_JAM_OFF_BIT = 2;
    localparam logic [3:0] MODE_LOCAL = 4'h4;
    localparam int HOURS_PER_DAY = 24;

    // ==================================================================
    // Jam threshold in offset units
    localparam int TICK_NS = 100;
    localparam int JAM_LIMIT_NS = 1000000;
    localparam int JAM_LIMIT_TICKS = JAM_LIMIT_NS / TICK_NS;
    localparam int DIFF_WIDTH = 32;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BODY = 2'b10
    } tspi_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tspi_bus_s;

    typedef struct packed {
        logic [7:0] propSign;
        logic [55:0] propDigits;
        logic [7:0] format;
        logic [7:0] modulation;
        logic extClock;
        logic [7:0] genCode;
        logic [3:0] pathA;
        logic [3:0] pathB;
        logic [7:0] localSign;
        logic [7:0] localTens;
        logic [7:0] localUnits;
    } tspi_setup_s;

endpackage : tspi_pkg
